// ---- txp_consts.svh ----
// field positions, register offsets and reset values of the transmit command parser
`ifndef TXP_CONSTS_SVH
`define TXP_CONSTS_SVH

// ============================================================
// command word a
`define A_FIRST_BIT  13
`define A_LAST_BIT   12
`define A_SIZE_MSB   10
`define A_OFF_MSB    20
`define A_OFF_LSB    16
`define A_ALIGN_MSB  25
`define A_ALIGN_LSB  24
`define ALIGN_16     2'h1
`define ALIGN_32     2'h2
`define MASK_4       12'h003
`define MASK_16      12'h00F
`define MASK_32      12'h01F

// ============================================================
// command word b
`define B_TAG_MSB    31
`define B_TAG_LSB    16
`define B_NOCRC_BIT  13
`define B_NOPAD_BIT  12
`define B_LEN_MSB    10

// ============================================================
// register port
`define REG_ADDR_W   8
`define REG_CTRL     8'h00
`define REG_STAT     8'h04
`define REG_TAG      8'h08
`define CTRL_EN_RST  1'h1

`endif

// ---- txp_pkg.sv ----
// state types of the transmit command parser
`default_nettype none
package txp_pkg;
	typedef enum logic [4:0] {
		S_CMDA   = 5'h01,
		S_CMDB   = 5'h02,
		S_HOLD   = 5'h04,
		S_BODY   = 5'h08,
		S_UNPACK = 5'h10,
		S_DONE   = 5'h00
	} parse_state_type;
	typedef enum logic [2:0] {
		D_IDLE  = 3'h1,
		D_FETCH = 3'h2,
		D_SHOW  = 3'h4
	} drain_state_type;
endpackage
`default_nettype wire

// ---- txp_store_mem.sv ----
// byte store for one packet with registered read data
`default_nettype none
module txp_store_mem #(
	parameter int AW = 11,
	parameter int DW = 8
) (
	input  wire logic          i_clock,
	input  wire logic          i_arst_n,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	input  wire logic          i_re,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [DW-1:0] o_rdata
);
	logic [DW-1:0] mem_ff [0:(1<<AW)-1];

	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem_ff[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= '0;
		end else if (i_re) begin
			o_rdata <= mem_ff[i_raddr];
		end
	end
endmodule
`default_nettype wire

// ---- tx_buffer_command_parser.sv ----
// transmit buffer command parser with store-and-forward byte store
// How it works
// RQ1: command a bits 13 and 12 mark first and last segment; they delimit packets.
// RQ2: command a bits 10:0 hold payload bytes, without offset or end filler.
// RQ3: start offset plus size with end alignment gives the number of buffer words to consume.
// RQ4: buffer sizes are summed per packet; mismatch with length sets error flag.
// RQ5: command b bits 31:16 carry a host tag, copied to the status word.
// RQ6: command b bit 13 suppresses the appended frame check sequence.
// RQ7: command b bit 12 suppresses short-frame padding and forces the checksum on.
// RQ8: command b bits 10:0 hold packet length; a differing byte count is an error.
// RQ9: host writes zeros to all reserved command bits.
// RQ10: buffer data starts in the word after the command words.
// RQ11: offset bits 1:0 pick the first valid byte lane of the first data word.
// RQ12: offset bits 4:2 skip up to seven whole words, never forwarded.
// RQ13: trailing unused bytes of the final data word are not forwarded.
// RQ14: end filler to 4, 16 or 32 bytes is removed by the device.
// RQ15: buffers may start and end on any byte; first and last any length.
// RQ16: host keeps middle buffers at least four bytes long.
// RQ17: a packet is stored completely before any byte goes to the mac.
// RQ18: host keeps a packet within 2036 bytes of mac fifo space.
// RQ19: host may treat more than 86 buffers as too fragmented.
// RQ20: start offset sits in command a bits 20:16, range 0 to 31.
// RQ21: status word bits 31:16 return the tag from command b.
// RQ22: command b follows only a first segment; first plus last is one packet.
// RQ23: the error flag stays set until software clears it.
`default_nettype none
`include "txp_consts.svh"
module tx_buffer_command_parser
	import txp_pkg::*;
#(
	parameter int AW = 11
) (
	input  wire logic                   I_CLOCK,
	input  wire logic                   I_ARST_N,
	input  wire logic                   I_TXD_VALID,
	input  wire logic [31:0]            I_TXD_DATA,
	output logic                        O_TXD_READY,
	output logic                        O_MAC_VALID,
	output logic [7:0]                  O_MAC_BYTE,
	output logic                        O_MAC_LAST,
	input  wire logic                   I_MAC_READY,
	output logic                        O_MAC_NO_CRC,
	output logic                        O_MAC_NO_PAD,
	output logic                        O_STAT_VALID,
	output logic [31:0]                 O_STAT_WORD,
	input  wire logic [`REG_ADDR_W-1:0] I_REG_ADDR,
	input  wire logic [31:0]            I_REG_WDATA,
	input  wire logic                   I_REG_WR,
	input  wire logic                   I_REG_RD,
	output logic [31:0]                 O_REG_RDATA
);
	// ============================================================
	// declarations
	parse_state_type state_ff;
	parse_state_type nxt_state;
	drain_state_type drain_ff;
	logic [9:0]  words_ff;
	logic [9:0]  wcnt_ff;
	logic [2:0]  skip_ff;
	logic [1:0]  lane0_ff;
	logic [1:0]  lane_ff;
	logic [10:0] rem_ff;
	logic [11:0] sum_ff;
	logic [10:0] len_ff;
	logic [15:0] tag_ff;
	logic [31:0] word_ff;
	logic        last_seg_ff;
	logic        in_pkt_ff;
	logic        nocrc_ff;
	logic        nopad_ff;
	logic        en_ff;
	logic        err_ff;
	logic        ready_ff;
	logic        mac_valid_ff;
	logic        mac_last_ff;
	logic [7:0]  mac_byte_ff;
	logic        stat_valid_ff;
	logic [31:0] stat_word_ff;
	logic [31:0] rdata_ff;
	logic [AW:0] wr_ptr_ff;
	logic [AW:0] commit_ff;
	logic [AW:0] rd_ptr_ff;
	logic [AW:0] fill;
	logic [7:0]  mem_q;
	logic [7:0]  wr_byte;
	logic [11:0] span;
	logic [11:0] mask;
	logic [11:0] padded;
	logic [9:0]  a_words;
	logic        take;
	logic        a_first;
	logic        discard;
	logic        last_word;
	logic        byte_end;
	logic        wr_en;
	logic        rd_en;
	logic        full;
	logic        out_idle;
	logic        buf_done;
	logic        pkt_end;
	logic        mismatch;
	logic        err_clr;

	// ============================================================
	// command word a decode
	assign take    = I_TXD_VALID && ready_ff;
	assign a_first = I_TXD_DATA[`A_FIRST_BIT];
	assign span    = {1'b0, I_TXD_DATA[`A_SIZE_MSB:0]} +
	                 {7'h00, I_TXD_DATA[`A_OFF_MSB:`A_OFF_LSB]};
	always_comb begin
		case (I_TXD_DATA[`A_ALIGN_MSB:`A_ALIGN_LSB])
			`ALIGN_16: mask = `MASK_16;
			`ALIGN_32: mask = `MASK_32;
			// reserved code falls back to word alignment
			default:   mask = `MASK_4;
		endcase
	end
	assign padded  = (span + mask) & ~mask;                          // [RQ14]
	assign a_words = padded[11:2];                                   // [RQ3]

	assign discard   = ({7'h00, skip_ff} > wcnt_ff) || (rem_ff == 11'h000); // [RQ12]
	assign last_word = (wcnt_ff + 10'h001) == words_ff;
	assign byte_end  = (rem_ff == 11'h001) || (lane_ff == 2'h3);      // [RQ13]
	assign fill      = wr_ptr_ff - rd_ptr_ff;
	assign full      = fill[AW];
	assign wr_en     = (state_ff == S_UNPACK) && !full;
	assign wr_byte   = word_ff[{lane_ff, 3'b000} +: 8];
	assign out_idle  = (drain_ff == D_IDLE) && (rd_ptr_ff == commit_ff);
	assign mismatch  = !in_pkt_ff || (sum_ff != {1'b0, len_ff});     // [RQ4]
	assign pkt_end   = buf_done && last_seg_ff;

	// ============================================================
	// parse sequencing
	always_comb begin
		nxt_state = state_ff;
		buf_done  = 1'b0;
		case (state_ff)
			S_CMDA: if (take) begin
				if (a_first) begin
					// a new packet waits until the store has drained
					nxt_state = out_idle ? S_CMDB : S_HOLD;  // [RQ22]
				end else if (a_words == 10'h000) begin
					nxt_state = S_DONE;
				end else begin
					nxt_state = S_BODY;
				end
			end
			S_HOLD: if (out_idle) begin
				nxt_state = S_CMDB;                      // [RQ17]
			end
			S_CMDB: if (take) begin
				nxt_state = (words_ff == 10'h000) ? S_DONE : S_BODY; // [RQ10]
			end
			S_BODY: if (take) begin
				if (!discard) begin
					nxt_state = S_UNPACK;
				end else if (last_word) begin
					nxt_state = S_DONE;
				end
			end
			S_UNPACK: if (wr_en && byte_end) begin
				nxt_state = (wcnt_ff == words_ff) ? S_DONE : S_BODY;
			end
			S_DONE: begin
				buf_done  = 1'b1;
				nxt_state = S_CMDA;
			end
			default: nxt_state = S_CMDA;
		endcase
	end

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_ff <= S_CMDA;
			ready_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ready_ff <= en_ff && ((nxt_state == S_CMDA) || (nxt_state == S_CMDB) ||
			            (nxt_state == S_BODY));
		end
	end

	// ============================================================
	// buffer bookkeeping
	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			words_ff    <= 10'h000;
			wcnt_ff     <= 10'h000;
			skip_ff     <= 3'h0;
			lane0_ff    <= 2'h0;
			lane_ff     <= 2'h0;
			rem_ff      <= 11'h000;
			last_seg_ff <= 1'b0;
			word_ff     <= 32'h00000000;
		end else if (take && (state_ff == S_CMDA)) begin
			words_ff    <= a_words;
			wcnt_ff     <= 10'h000;
			skip_ff     <= I_TXD_DATA[`A_OFF_LSB+4:`A_OFF_LSB+2];   // [RQ12] [RQ20]
			lane0_ff    <= I_TXD_DATA[`A_OFF_LSB+1:`A_OFF_LSB];     // [RQ11]
			rem_ff      <= I_TXD_DATA[`A_SIZE_MSB:0];               // [RQ2]
			last_seg_ff <= I_TXD_DATA[`A_LAST_BIT];                 // [RQ1]
		end else if (take && (state_ff == S_BODY)) begin
			wcnt_ff <= wcnt_ff + 10'h001;
			if (!discard) begin
				word_ff <= I_TXD_DATA;
				lane_ff <= ({7'h00, skip_ff} == wcnt_ff) ? lane0_ff : 2'h0; // [RQ11]
			end
		end else if (wr_en) begin
			rem_ff  <= rem_ff - 11'h001;
			lane_ff <= lane_ff + 2'h1;
		end
	end

	// ============================================================
	// packet bookkeeping
	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sum_ff    <= 12'h000;
			in_pkt_ff <= 1'b0;
		end else if (take && (state_ff == S_CMDA)) begin
			sum_ff <= (a_first ? 12'h000 : sum_ff) + {1'b0, I_TXD_DATA[`A_SIZE_MSB:0]}; // [RQ4]
			if (a_first) begin
				in_pkt_ff <= 1'b1;                                   // [RQ1]
			end
		end else if (pkt_end) begin
			in_pkt_ff <= 1'b0;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tag_ff   <= 16'h0000;
			len_ff   <= 11'h000;
			nocrc_ff <= 1'b0;
			nopad_ff <= 1'b0;
		end else if (take && (state_ff == S_CMDB)) begin
			tag_ff   <= I_TXD_DATA[`B_TAG_MSB:`B_TAG_LSB];           // [RQ5]
			len_ff   <= I_TXD_DATA[`B_LEN_MSB:0];                    // [RQ8]
			// checksum stays on whenever padding is suppressed, so the output is a plain flop
			nocrc_ff <= I_TXD_DATA[`B_NOCRC_BIT] && !I_TXD_DATA[`B_NOPAD_BIT]; // [RQ6] [RQ7]
			nopad_ff <= I_TXD_DATA[`B_NOPAD_BIT];                    // [RQ7]
		end
	end

	// ============================================================
	// store pointers
	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			wr_ptr_ff <= '0;
			commit_ff <= '0;
		end else begin
			// a fresh first segment or a bad length throws away uncommitted bytes
			if ((take && (state_ff == S_CMDA) && a_first) || (pkt_end && mismatch)) begin
				wr_ptr_ff <= commit_ff;                              // [RQ8] [RQ22]
			end else if (wr_en) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;                       // [RQ15]
			end
			if (pkt_end && !mismatch) begin
				commit_ff <= wr_ptr_ff;                              // [RQ17]
			end
		end
	end

	// ============================================================
	// drain to the mac, one committed packet at a time
	assign rd_en = (drain_ff == D_IDLE) && (rd_ptr_ff != commit_ff);

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			drain_ff      <= D_IDLE;
			rd_ptr_ff     <= '0;
			mac_valid_ff  <= 1'b0;
			mac_last_ff   <= 1'b0;
			mac_byte_ff   <= 8'h00;
			stat_valid_ff <= 1'b0;
			stat_word_ff  <= 32'h00000000;
		end else begin
			stat_valid_ff <= 1'b0;
			case (drain_ff)
				D_IDLE: if (rd_en) begin
					drain_ff <= D_FETCH;
				end
				D_FETCH: begin
					mac_byte_ff  <= mem_q;
					mac_valid_ff <= 1'b1;
					mac_last_ff  <= (rd_ptr_ff + 1'b1) == commit_ff;
					rd_ptr_ff    <= rd_ptr_ff + 1'b1;
					drain_ff     <= D_SHOW;
				end
				D_SHOW: if (I_MAC_READY) begin
					mac_valid_ff <= 1'b0;
					drain_ff     <= D_IDLE;
					if (mac_last_ff) begin
						stat_valid_ff <= 1'b1;
						stat_word_ff  <= {tag_ff, 16'h0000};         // [RQ21]
					end
				end
				default: drain_ff <= D_IDLE;
			endcase
		end
	end

	txp_store_mem #(.AW(AW), .DW(8)) u_store (
		.i_clock (I_CLOCK),
		.i_arst_n(I_ARST_N),
		.i_we    (wr_en),
		.i_waddr (wr_ptr_ff[AW-1:0]),
		.i_wdata (wr_byte),
		.i_re    (rd_en),
		.i_raddr (rd_ptr_ff[AW-1:0]),
		.o_rdata (mem_q)
	);

	// ============================================================
	// register port
	assign err_clr = I_REG_WR && (I_REG_ADDR == `REG_STAT) && I_REG_WDATA[0];

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			en_ff <= `CTRL_EN_RST;
		end else if (I_REG_WR && (I_REG_ADDR == `REG_CTRL)) begin
			en_ff <= I_REG_WDATA[0];
		end
	end

	// a mismatch in the clearing cycle wins over the clear
	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			err_ff <= 1'b0;
		end else if (pkt_end && mismatch) begin
			err_ff <= 1'b1;                                          // [RQ4]
		end else if (err_clr) begin
			err_ff <= 1'b0;                                          // [RQ23]
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rdata_ff <= 32'h00000000;
		end else if (I_REG_RD) begin
			case (I_REG_ADDR)
				`REG_CTRL: rdata_ff <= {31'h00000000, en_ff};
				`REG_STAT: rdata_ff <= {25'h0000000, state_ff, !out_idle, err_ff};
				`REG_TAG:  rdata_ff <= {16'h0000, stat_word_ff[31:16]};
				default:   rdata_ff <= 32'h00000000;
			endcase
		end else begin
			rdata_ff <= 32'h00000000;
		end
	end

	assign O_TXD_READY  = ready_ff;
	assign O_MAC_VALID  = mac_valid_ff;
	assign O_MAC_BYTE   = mac_byte_ff;
	assign O_MAC_LAST   = mac_last_ff;
	assign O_MAC_NO_CRC = nocrc_ff;                                  // [RQ6] [RQ7]
	assign O_MAC_NO_PAD = nopad_ff;
	assign O_STAT_VALID = stat_valid_ff;
	assign O_STAT_WORD  = stat_word_ff;
	assign O_REG_RDATA  = rdata_ff;

	// ============================================================
	// assertions
	sequence s_fetch;
		(drain_ff == D_IDLE) && (rd_ptr_ff != commit_ff) ##1 (drain_ff == D_FETCH);
	endsequence

	property p_fetch_show;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		s_fetch |=> mac_valid_ff && (drain_ff == D_SHOW);
	endproperty
	a_fetch_show: assert property (p_fetch_show) else $error("byte not shown after fetch"); // [RQ17]

	property p_hold_blocks;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		(state_ff == S_HOLD) |-> !ready_ff && !wr_en;
	endproperty
	a_hold_blocks: assert property (p_hold_blocks) else $error("hold state misbehaves"); // [RQ17]

	property p_first_to_cmdb;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		take && (state_ff == S_CMDA) && a_first |=> (state_ff == S_CMDB) || (state_ff == S_HOLD);
	endproperty
	a_first_to_cmdb: assert property (p_first_to_cmdb) else $error("first segment skipped word b"); // [RQ22]

	property p_err_set;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		pkt_end && mismatch |=> err_ff && (wr_ptr_ff == commit_ff) && $stable(commit_ff);
	endproperty
	a_err_set: assert property (p_err_set) else $error("length mismatch not flagged"); // [RQ4]

	property p_err_sticky;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		err_ff && !err_clr |=> err_ff;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped"); // [RQ23]

	property p_commit;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		pkt_end && !mismatch |=> (commit_ff == $past(wr_ptr_ff)) && (!err_ff || $past(err_ff));
	endproperty
	a_commit: assert property (p_commit) else $error("good packet not committed"); // [RQ8]

	property p_skip;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		take && (state_ff == S_BODY) && discard |=> (state_ff != S_UNPACK) && !wr_en;
	endproperty
	a_skip: assert property (p_skip) else $error("skipped word forwarded"); // [RQ12]

	property p_lane_first;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		take && (state_ff == S_BODY) && !discard && ({7'h00, skip_ff} == wcnt_ff)
		|=> (lane_ff == $past(lane0_ff)) && (state_ff == S_UNPACK);
	endproperty
	a_lane_first: assert property (p_lane_first) else $error("wrong first byte lane"); // [RQ11]

	property p_stat_tag;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		O_MAC_VALID && O_MAC_LAST && I_MAC_READY |=> O_STAT_VALID && (O_STAT_WORD[31:16] == tag_ff);
	endproperty
	a_stat_tag: assert property (p_stat_tag) else $error("status tag wrong"); // [RQ21]

	property p_crc_forced;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		O_MAC_NO_PAD |-> !O_MAC_NO_CRC;
	endproperty
	a_crc_forced: assert property (p_crc_forced) else $error("checksum dropped with no pad"); // [RQ7]

	property p_ready_states;
		@(posedge I_CLOCK) disable iff (!I_ARST_N)
		ready_ff |-> (state_ff == S_CMDA) || (state_ff == S_CMDB) || (state_ff == S_BODY);
	endproperty
	a_ready_states: assert property (p_ready_states) else $error("ready in busy state"); // [RQ1]
endmodule
`default_nettype wire

// ---- txp_host_model.sv ----
// host model that builds transmit buffers and offers them word by word
`default_nettype none
module txp_host_model (
	input  wire logic        i_clock,
	input  wire logic        i_ready,
	output logic             o_valid,
	output logic [31:0]      o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] q[$];
	int          slow = 0;
	int          gap = 0;
	int          bufs = 0;
	int          used = 0;
	// ============================================================
	// buffer builder
	task automatic put_buffer(input logic first, input logic last, input logic [4:0] off,
		input logic [10:0] size, input logic [1:0] align, input logic [15:0] tag,
		input logic [10:0] len, input logic nocrc, input logic nopad, input logic [7:0] seed);
		int         span;
		int         total;
		logic [7:0] b;
		logic [31:0] w;
		span = (align == 2'h1) ? 16 : (align == 2'h2) ? 32 : 4;
		total = ((off + size + span - 1) / span) * span;
		bufs = first ? 1 : bufs + 1;
		// mac fifo space: partial words at both ends plus the whole words between
		used = (first ? 0 : used) + ((off % 4) + size + 3) / 4 * 4;
		if ((!first && !last && size < 4) || bufs > 86 || used > 2036) begin
			$display("host model asked for an illegal buffer at %0t", $time);
		end
		q.push_back({6'h00, align, 3'h0, off, 2'h0, first, last, 1'b0, size});
		if (first) begin
			q.push_back({tag, 2'h0, nocrc, nopad, 1'b0, len});
		end
		for (int p = 0; p < total; p++) begin
			if (p >= off && p < off + size) begin
				b = seed + 8'(p - off);
			end else begin
				b = 8'hE7 ^ 8'(p);
			end
			w = {b, w[31:8]};
			if (p % 4 == 3) begin
				q.push_back(w);
			end
		end
	endtask
	// ============================================================
	// word driver: holds a word until ready is seen at an edge
	initial begin
		o_valid = 1'b0;
		o_data = 32'h00000000;
		forever begin
			@(posedge i_clock);
			if (o_valid && i_ready) begin
				gap = slow;
			end
			if (!o_valid || i_ready) begin
				if (q.size() != 0 && gap == 0) begin
					o_valid <= 1'b1;
					o_data <= q.pop_front();
				end else begin
					// idle data toggles so a stale word is never mistaken for a valid one
					o_valid <= 1'b0;
					o_data <= ~o_data;
					if (gap > 0) begin
						gap--;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- test_tx_buffer_command_parser.sv ----
// self-checking bench of the transmit command parser with host model and stalling mac sink
`default_nettype none
`include "txp_consts.svh"
module test_tx_buffer_command_parser;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [4:0]  off;
		logic [10:0] size;
		logic [1:0]  align;
		logic        nocrc;
		logic        nopad;
		logic [15:0] tag;
		logic        exp_nocrc;
		logic        exp_nopad;
	} row_type;
	row_type rows [7] = '{
		'{5'h00, 11'h004, 2'h0, 1'h0, 1'h0, 16'h1A01, 1'h0, 1'h0},
		'{5'h01, 11'h001, 2'h0, 1'h1, 1'h0, 16'h1A02, 1'h1, 1'h0},
		'{5'h02, 11'h005, 2'h1, 1'h0, 1'h1, 16'h1A03, 1'h0, 1'h1},
		'{5'h03, 11'h009, 2'h2, 1'h1, 1'h1, 16'h1A04, 1'h0, 1'h1},
		'{5'h1F, 11'h003, 2'h2, 1'h0, 1'h0, 16'h1A05, 1'h0, 1'h0},
		'{5'h04, 11'h040, 2'h0, 1'h1, 1'h0, 16'h1A06, 1'h1, 1'h0},
		'{5'h02, 11'h007, 2'h3, 1'h0, 1'h0, 16'h1A07, 1'h0, 1'h0}
	};
	logic                   clock, arst_n, txd_valid, txd_ready, mac_valid, mac_last, mac_ready;
	logic                   no_crc, no_pad, stat_valid, reg_wr, reg_rd;
	logic                   cap_nocrc, cap_nopad, cap_saf;
	logic [31:0]            txd_data, stat_word, stat_seen, reg_wdata, reg_rdata, rd;
	logic [7:0]             mac_byte;
	logic [`REG_ADDR_W-1:0] reg_addr;
	logic [7:0]             exp_q[$], got_q[$];
	logic                   last_q[$];
	int                     fails = 0, samples_checked = 0, stat_cnt = 0, cyc = 0;

	txp_host_model host (.i_clock(clock), .i_ready(txd_ready), .o_valid(txd_valid),
		.o_data(txd_data));
	tx_buffer_command_parser #(.AW(11)) dut (.I_CLOCK(clock), .I_ARST_N(arst_n),
		.I_TXD_VALID(txd_valid), .I_TXD_DATA(txd_data), .O_TXD_READY(txd_ready),
		.O_MAC_VALID(mac_valid), .O_MAC_BYTE(mac_byte), .O_MAC_LAST(mac_last),
		.I_MAC_READY(mac_ready), .O_MAC_NO_CRC(no_crc), .O_MAC_NO_PAD(no_pad),
		.O_STAT_VALID(stat_valid), .O_STAT_WORD(stat_word), .I_REG_ADDR(reg_addr),
		.I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// ============================================================
	// mac sink: stalls every third cycle, records bytes and status
	always @(posedge clock) begin
		cyc <= cyc + 1;
		mac_ready <= (cyc % 3) != 0;
		if (mac_valid && mac_ready) begin
			if (got_q.size() == 0) begin
				cap_nocrc = no_crc;
				cap_nopad = no_pad;
				cap_saf = !txd_valid && host.q.size() == 0;
			end
			got_q.push_back(mac_byte);
			last_q.push_back(mac_last);
		end
		if (stat_valid) begin
			stat_cnt++;
			stat_seen = stat_word;
		end
	end
	// ============================================================
	// compare and bus tasks
	task automatic fail_msg(input string m);
		fails++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) fail_msg($sformatf("byte %h want %h", got, exp));
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) fail_msg($sformatf("word %h want %h", got, exp));
	endtask
	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) fail_msg($sformatf("flag %b want %b", got, exp));
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic add_exp(input logic [7:0] seed, input int size);
		for (int i = 0; i < size; i++) exp_q.push_back(seed + 8'(i));
	endtask
	task automatic wait_idle(input int extra);
		int n;
		n = 0;
		while ((txd_valid || host.q.size() != 0) && n < 3000) begin
			@(posedge clock);
			n++;
		end
		repeat (extra) @(posedge clock);
	endtask
	task automatic expect_pkt(input logic [15:0] tag, input logic nc, input logic np);
		int n;
		n = 0;
		while (stat_cnt == 0 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		repeat (4) @(posedge clock);
		chk32(32'(stat_cnt), 32'h00000001);
		chk32(stat_seen, {tag, 16'h0000});
		chk32(32'(got_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) begin
			chk8(got_q[i], exp_q[i]);
			chk1(last_q[i], i == exp_q.size() - 1);
		end
		chk1(cap_nocrc, nc);
		chk1(cap_nopad, np);
		chk1(cap_saf, 1'b1);
		got_q.delete();
		last_q.delete();
		exp_q.delete();
		stat_cnt = 0;
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ============================================================
	// main sequence
	initial begin
		arst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (8) @(posedge clock);
		#1 chk1(mac_valid, 1'b0);
		chk1(stat_valid, 1'b0);
		@(posedge clock);
		arst_n <= 1'b1;
		reg_read(`REG_CTRL, rd);
		chk32(rd, 32'h00000001);
		reg_read(8'h0C, rd);
		chk32(rd, 32'h00000000);
		foreach (rows[r]) begin
			host.slow = r % 2;
			host.put_buffer(1'b1, 1'b1, rows[r].off, rows[r].size, rows[r].align, rows[r].tag,
				rows[r].size, rows[r].nocrc, rows[r].nopad, rows[r].tag[7:0]);
			add_exp(rows[r].tag[7:0], int'(rows[r].size));
			expect_pkt(rows[r].tag, rows[r].exp_nocrc, rows[r].exp_nopad);
		end
		// three segments with start offsets and 16-byte end filler
		host.put_buffer(1'b1, 1'b0, 5'h07, 11'h04F, 2'h1, 16'h2B02, 11'h06F, 1'b0, 1'b0, 8'h10);
		host.put_buffer(1'b0, 1'b0, 5'h00, 11'h00F, 2'h1, 16'h0000, 11'h000, 1'b0, 1'b0, 8'h70);
		host.put_buffer(1'b0, 1'b1, 5'h0A, 11'h011, 2'h1, 16'h0000, 11'h000, 1'b0, 1'b0, 8'hA0);
		add_exp(8'h10, 79);
		add_exp(8'h70, 15);
		add_exp(8'hA0, 17);
		expect_pkt(16'h2B02, 1'b0, 1'b0);
		// length mismatch drops the packet and latches the error
		host.put_buffer(1'b1, 1'b1, 5'h00, 11'h008, 2'h0, 16'h3C03, 11'h009, 1'b0, 1'b0, 8'h33);
		wait_idle(40);
		chk32(32'(stat_cnt), 32'h00000000);
		reg_read(`REG_STAT, rd);
		chk1(rd[0], 1'b1);
		host.put_buffer(1'b1, 1'b1, 5'h00, 11'h004, 2'h0, 16'h3C04, 11'h004, 1'b0, 1'b0, 8'h44);
		add_exp(8'h44, 4);
		expect_pkt(16'h3C04, 1'b0, 1'b0);
		reg_read(`REG_STAT, rd);
		chk1(rd[0], 1'b1);
		reg_write(`REG_STAT, 32'h00000001);
		reg_read(`REG_STAT, rd);
		chk1(rd[0], 1'b0);
		// a last segment with no first segment before it
		host.put_buffer(1'b0, 1'b1, 5'h00, 11'h004, 2'h0, 16'h0000, 11'h000, 1'b0, 1'b0, 8'h55);
		wait_idle(40);
		chk32(32'(stat_cnt), 32'h00000000);
		reg_read(`REG_STAT, rd);
		chk1(rd[0], 1'b1);
		reg_write(`REG_STAT, 32'h00000001);
		// disabled parser leaves the host word waiting
		reg_write(`REG_CTRL, 32'h00000000);
		host.put_buffer(1'b1, 1'b1, 5'h01, 11'h006, 2'h0, 16'h4D05, 11'h006, 1'b0, 1'b0, 8'h66);
		repeat (30) @(posedge clock);
		chk1(txd_valid, 1'b1);
		chk32(32'(stat_cnt), 32'h00000000);
		reg_write(`REG_CTRL, 32'h00000001);
		add_exp(8'h66, 6);
		expect_pkt(16'h4D05, 1'b0, 1'b0);
		complete_run();
	end
	initial begin
		#(25 * 20000);
		fail_msg("watchdog expired");
		complete_run();
	end
endmodule
`default_nettype wire
